// File: rtl/smrc_top.sv
`timescale 1ns/10ps
// Functional notes
// [RL1] four-bit code picks 2.3 to 3.8 V threshold
// [RL2] threshold code resets to 3.0 V setting
// [RL3] no power-up until supply above rising threshold
// [RL4] supply-low flag mirrors synchronised comparator
// [RL5] low condition holds until 200 mV above
// [RL6] interrupt mode and unmasked: drop asserts interrupt
// [RL7] interrupt clears after recovery and status read
// [RL8] shutdown mode: drop disables all rails, no interrupt
// [RL9] over-temperature disables rails, blocks re-enable
// [RL10] enabled rail ramps 400 us soft-start
// [RL11] rails start default code, accept new code
// [RL12] on/off bit edges enable or disable rail
// [RL13] host toggles on/off bit through opposite level
// [RL14] push-button enables rail three unless independent
// [RL15] host sets independence before entering sleep
// [RL16] turn-on delay code n gives 2**n ms, code 0 none
// [RL17] mode bit forces PWM, else auto power-save
// [RL18] shutdown causes override bits and timers
// [RL19] comparator inputs synchronised before use
module smrc_top (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic supply_below_cmp, // analog comparator: supply below threshold
  input wire logic over_temp_cmp, // analog comparator: die over-temperature
  input wire logic pushbutton_input, // push-button asserted, active high
  input wire logic [3:0] supply_threshold_code_wr, // threshold code to load
  input wire logic supply_threshold_code_we, // load threshold code
  input wire logic supply_low_response_select, // 1 interrupt, 0 shutdown
  input wire logic supply_alarm_unmask, // 1 lets supply alarm interrupt
  input wire logic supply_low_flag_rd, // host read of the status bit, pulse
  input wire logic rail3_button_independence, // 1 rail three ignores button
  input wire logic [2:0] rail_on, // per-rail on/off control bits
  input wire logic [8:0] rail_delay, // three-bit delay code per rail
  input wire logic [2:0] rail_mode, // per-rail forced-PWM bit
  input wire logic [17:0] vcode_wr, // six-bit voltage code per rail
  input wire logic [2:0] vcode_we, // per-rail voltage code load
  output logic [3:0] supply_threshold_code, // threshold code to comparator
  output logic supply_low_flag, // status: supply below threshold
  output logic interrupt_request_n, // interrupt, active low
  output logic powered_up, // supply qualified since last supply-low shutdown
  output logic [2:0] rail_enable, // per-rail converter enable
  output logic [2:0] rail_soft_start, // per-rail soft-start ramp running
  output logic [2:0] rail_good, // per-rail ramp finished
  output logic [2:0] rail_force_pwm, // per-rail forced PWM
  output logic [17:0] output_voltage_code // six-bit code per rail
);
  // synchroniser stages
  logic sup_s1, sup_s2, ot_s1, ot_s2;
  // control state
  logic [3:0] next_thr;
  logic next_flag, irq_pend, next_irq_pend, read_seen, next_read_seen;
  logic next_powered, uv_shut, next_uv_shut;
  logic [2:0] on_q; // previous on/off levels
  logic pb_q; // previous push-button level
  logic shutdown; // any shutdown cause active
  logic [17:0] next_vcode;
  logic [2:0] next_pwm;

  // two-flop synchronisers for the comparators
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sup_s1 <= 1'b1;
      sup_s2 <= 1'b1;
      ot_s1 <= 1'b0;
      ot_s2 <= 1'b0;
    end else begin
      sup_s1 <= supply_below_cmp; // RL19
      sup_s2 <= sup_s1;
      ot_s1 <= over_temp_cmp;
      ot_s2 <= ot_s1;
    end
  end

  // shutdown gate from thermal or supply-low response
  assign shutdown = ot_s2 | uv_shut; // RL9 RL18

  // supply monitor next values
  always_comb begin
    next_thr = supply_threshold_code;
    if (supply_threshold_code_we) begin
      next_thr = supply_threshold_code_wr; // RL1
    end
    // comparator carries the hysteresis; flag follows it
    next_flag = sup_s2; // RL4 RL5
    // power-up only once supply is above rising threshold
    next_powered = powered_up;
    next_uv_shut = uv_shut;
    if (!powered_up) begin
      if (!sup_s2 && !ot_s2) begin
        next_powered = 1'b1; // RL3
        next_uv_shut = 1'b0;
      end
    end else if (sup_s2 && !supply_low_response_select) begin
      next_powered = 1'b0; // RL8
      next_uv_shut = 1'b1;
    end
    // interrupt: set wins over clear
    next_irq_pend = irq_pend;
    next_read_seen = read_seen;
    if (irq_pend && supply_low_flag_rd) begin
      next_read_seen = 1'b1;
    end
    if (irq_pend && read_seen && !sup_s2) begin
      next_irq_pend = 1'b0; // RL7
      next_read_seen = 1'b0;
    end
    if (powered_up && sup_s2 && supply_low_response_select && supply_alarm_unmask) begin
      next_irq_pend = 1'b1; // RL6
      next_read_seen = read_seen & ~supply_low_flag_rd ? read_seen : next_read_seen;
    end
  end

  // supply monitor registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      supply_threshold_code <= smrc_pkg::THR_CODE_RESET; // RL2
      supply_low_flag <= 1'b1;
      powered_up <= 1'b0;
      uv_shut <= 1'b0;
      irq_pend <= 1'b0;
      read_seen <= 1'b0;
      interrupt_request_n <= 1'b1;
    end else begin
      supply_threshold_code <= next_thr;
      supply_low_flag <= next_flag;
      powered_up <= next_powered;
      uv_shut <= next_uv_shut;
      irq_pend <= next_irq_pend;
      read_seen <= next_read_seen;
      interrupt_request_n <= ~next_irq_pend;
    end
  end

  // voltage codes and mode bits
  always_comb begin
    next_vcode = output_voltage_code;
    next_pwm = rail_mode; // RL17
    for (int i = 0; i < smrc_pkg::NUM_RAILS; i++) begin
      if (vcode_we[i] && powered_up) begin
        next_vcode[i*smrc_pkg::VCODE_W +: smrc_pkg::VCODE_W] =
          vcode_wr[i*smrc_pkg::VCODE_W +: smrc_pkg::VCODE_W]; // RL11
      end
    end
  end

  // register codes, modes and edge history
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      output_voltage_code <= {smrc_pkg::NUM_RAILS{smrc_pkg::VCODE_RESET}};
      rail_force_pwm <= {smrc_pkg::NUM_RAILS{smrc_pkg::MODE_RESET}};
      on_q <= 3'h0;
      pb_q <= 1'b0;
    end else begin
      output_voltage_code <= next_vcode;
      rail_force_pwm <= next_pwm;
      on_q <= rail_on;
      pb_q <= pushbutton_input;
    end
  end

  // per-rail sequencer
  genvar g;
  generate
    for (g = 0; g < smrc_pkg::NUM_RAILS; g++) begin : rail
      smrc_timer_if tif ();
      smrc_pkg::smrc_rail_state_e st, next_st;
      logic rise, fall, pb_rise;
      logic [2:0] dcode;
      assign dcode = rail_delay[g*3 +: 3];
      assign pb_rise = (g == smrc_pkg::RAIL_THREE) && !rail3_button_independence
        && pushbutton_input && !pb_q; // RL14
      assign rise = (rail_on[g] & ~on_q[g]) | pb_rise; // RL12 RL13
      assign fall = ~rail_on[g] & on_q[g]; // RL12

      smrc_timer u_timer (
        .mclk(mclk),
        .rst_b(rst_b),
        .tif(tif.timer)
      );

      // rail next-state and timer requests
      always_comb begin
        next_st = st;
        tif.start = 1'b0;
        tif.clear = 1'b0;
        tif.load = 32'(smrc_pkg::SOFT_START_CYC); // RL10
        if (shutdown || !powered_up) begin
          next_st = smrc_pkg::SMRC_OFF; // RL18
          tif.clear = 1'b1;
        end else if (fall) begin
          next_st = smrc_pkg::SMRC_OFF;
          tif.clear = 1'b1;
        end else begin
          unique case (st)
            smrc_pkg::SMRC_OFF: begin
              if (rise) begin
                tif.start = 1'b1;
                if (dcode == 3'h0) begin
                  next_st = smrc_pkg::SMRC_RAMP;
                end else begin
                  next_st = smrc_pkg::SMRC_WAIT;
                  tif.load = 32'(smrc_pkg::MS_CYC) << dcode; // RL16
                end
              end
            end
            smrc_pkg::SMRC_WAIT: begin
              if (tif.done) begin
                next_st = smrc_pkg::SMRC_RAMP;
                tif.start = 1'b1;
              end
            end
            smrc_pkg::SMRC_RAMP: begin
              if (tif.done) begin
                next_st = smrc_pkg::SMRC_ON;
              end
            end
            smrc_pkg::SMRC_ON: begin
              next_st = smrc_pkg::SMRC_ON;
            end
          endcase
        end
      end

      // rail state and outputs
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          st <= smrc_pkg::SMRC_OFF;
          rail_enable[g] <= 1'b0;
          rail_soft_start[g] <= 1'b0;
          rail_good[g] <= 1'b0;
        end else begin
          st <= next_st;
          rail_enable[g] <= (next_st == smrc_pkg::SMRC_RAMP) || (next_st == smrc_pkg::SMRC_ON);
          rail_soft_start[g] <= next_st == smrc_pkg::SMRC_RAMP;
          rail_good[g] <= next_st == smrc_pkg::SMRC_ON;
        end
      end
    end
  endgenerate
endmodule

// File: rtl/smrc_pkg.sv
package smrc_pkg;
  // supply threshold code: 0000 is 2.3 V, 0.1 V a step, 1111 is 3.8 V
  localparam int THR_BASE_MV = 2300;
  localparam int THR_STEP_MV = 100;
  localparam logic [3:0] THR_CODE_RESET = 4'h7; // 3.0 V falling threshold
  localparam int HYST_MV = 200; // rising hysteresis above falling threshold
  // clock
  localparam int CLK_MHZ = 100;
  // soft-start ramp length
  localparam int SOFT_START_US = 400;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  // turn-on delay: one ms unit, code n gives 2**n ms, code 0 none
  localparam int DELAY_UNIT_MS = 1;
  localparam int MS_CYC = DELAY_UNIT_MS * 1000 * CLK_MHZ;
  localparam int NUM_RAILS = 3;
  localparam int RAIL_THREE = 2; // index of the push-button rail
  localparam int VCODE_W = 6; // output voltage code width
  localparam logic [5:0] VCODE_RESET = 6'h00; // default voltage code
  localparam logic RESP_RESET = 1'b1; // interrupt response after reset
  localparam logic UNMASK_RESET = 1'b0; // alarm masked after reset
  localparam logic INDEP_RESET = 1'b0; // rail three follows push-button
  localparam logic MODE_RESET = 1'b0; // auto power-save after reset
  typedef enum logic [1:0] {
    SMRC_OFF,
    SMRC_WAIT,
    SMRC_RAMP,
    SMRC_ON
  } smrc_rail_state_e;
endpackage

// File: rtl/smrc_timer_if.sv
`timescale 1ns/10ps
// one rail's timer request and answer
interface smrc_timer_if;
  logic start; // load and run the timer
  logic clear; // stop the timer
  logic [31:0] load; // cycles to count
  logic done; // one-cycle pulse at expiry
  modport owner (output start, output clear, output load, input done);
  modport timer (input start, input clear, input load, output done);
endinterface

// File: rtl/smrc_timer.sv
`timescale 1ns/10ps
// down counter shared by delay and soft-start phases of one rail
module smrc_timer (
  input wire logic mclk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  smrc_timer_if.timer tif // request and answer
);
  logic [31:0] count; // remaining cycles
  logic running; // counting
  logic done; // expiry pulse
  logic [31:0] next_count;
  logic next_running;
  logic next_done;

  // next-state of the counter
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (tif.clear) begin
      next_running = 1'b0;
    end else if (tif.start) begin
      next_count = tif.load;
      next_running = 1'b1;
    end else if (running) begin
      // pulse one cycle early: the owner's registered reaction lands on the last cycle
      if (count <= 32'h2) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 32'h1;
      end
    end
  end

  // register the counter
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count <= 32'h0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end

  assign tif.done = done;
endmodule

// File: dv/smrc_top_sva.sv
`timescale 1ns/10ps
// watches monitor and rail outputs
module smrc_top_sva (
  input wire logic mclk, // clock
  input wire logic rst_b, // reset
  input wire logic supply_below_cmp, // low in
  input wire logic over_temp_cmp, // hot in
  input wire logic [3:0] supply_threshold_code_wr, // code in
  input wire logic supply_threshold_code_we, // load
  input wire logic supply_low_response_select, // mode
  input wire logic supply_alarm_unmask, // unmask
  input wire logic [2:0] rail_on, // on bits
  input wire logic [3:0] supply_threshold_code, // code
  input wire logic supply_low_flag, // status
  input wire logic interrupt_request_n, // irq
  input wire logic powered_up, // up
  input wire logic [2:0] rail_enable, // enables
  input wire logic [2:0] rail_soft_start, // ramps
  input wire logic [2:0] rail_good // done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  int ss_cnt; // ramp cycles, rail one
  int next_ss_cnt; // next count
  // count ramp cycles
  always_comb begin
    next_ss_cnt = rail_soft_start[0] ? ss_cnt + 1 : 0;
  end
  always_ff @(posedge mclk) begin
    ss_cnt <= next_ss_cnt;
  end
  a_thr_reset: assert property (!$past(rst_b) |->
    supply_threshold_code == smrc_pkg::THR_CODE_RESET) else $error("bad reset code");
  a_thr_load: assert property (supply_threshold_code_we |=>
    supply_threshold_code == $past(supply_threshold_code_wr)) else $error("code not loaded");
  a_flag_sync: assert property ($past(rst_b, 3) && $past(rst_b, 2) && $past(rst_b) |->
    supply_low_flag == $past(supply_below_cmp, 3)) else $error("flag lag wrong");
  a_irq_raise: assert property (powered_up && supply_low_flag && supply_alarm_unmask &&
    supply_low_response_select |-> ##[1:2] !interrupt_request_n) else $error("no irq");
  a_irq_mode: assert property ($fell(interrupt_request_n) |->
    $past(supply_low_response_select) && $past(supply_alarm_unmask)) else $error("stray irq");
  a_irq_hold: assert property ($rose(interrupt_request_n) |-> !supply_low_flag)
    else $error("irq cleared while low");
  a_sd_rails: assert property (!supply_low_response_select && supply_low_flag |->
    ##[1:3] (rail_enable == 3'h0 && !powered_up)) else $error("no shutdown");
  a_hot_off: assert property (over_temp_cmp [*4] |=> rail_enable == 3'h0)
    else $error("rail on while hot");
  a_ramp_len: assert property ($rose(rail_good[0]) |->
    ss_cnt == smrc_pkg::SOFT_START_CYC) else $error("ramp length wrong");
  a_off_edge: assert property ($fell(rail_on[1]) |-> ##[1:4] !rail_enable[1])
    else $error("rail not off");
  c_irq: cover property (!interrupt_request_n);
  c_good: cover property ($rose(rail_good[0]));
  c_down: cover property ($fell(powered_up));
endmodule
bind smrc_top smrc_top_sva u_sva (.mclk(mclk), .rst_b(rst_b),
  .supply_below_cmp(supply_below_cmp), .over_temp_cmp(over_temp_cmp),
  .supply_threshold_code_wr(supply_threshold_code_wr),
  .supply_threshold_code_we(supply_threshold_code_we),
  .supply_low_response_select(supply_low_response_select),
  .supply_alarm_unmask(supply_alarm_unmask), .rail_on(rail_on),
  .supply_threshold_code(supply_threshold_code), .supply_low_flag(supply_low_flag),
  .interrupt_request_n(interrupt_request_n), .powered_up(powered_up),
  .rail_enable(rail_enable), .rail_soft_start(rail_soft_start), .rail_good(rail_good));

// File: dv/smrc_host_model.sv
`timescale 1ns/10ps
// host: reads status while irq pending
module smrc_host_model (
  input wire logic mclk, // clock
  input wire logic service, // reads allowed
  input wire logic interrupt_request_n, // irq
  output logic supply_low_flag_rd // read pulse
);
  logic next_rd; // next pulse
  // one read every second cycle
  always_comb begin
    next_rd = service && !interrupt_request_n && !supply_low_flag_rd;
  end
  always_ff @(posedge mclk) begin
    supply_low_flag_rd <= next_rd;
  end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/10ps
// drives monitor and rails
module tb_top;
  logic mclk = 1'b0; // clock
  logic rst_b = 1'b0; // reset
  logic lo = 1'b0; // supply low
  logic hot = 1'b0; // over temp
  logic btn = 1'b0; // button
  logic [3:0] twr = 4'h0; // code in
  logic twe = 1'b0; // code load
  logic sel = 1'b1; // 1 irq
  logic unm = 1'b1; // unmask
  logic ind = 1'b0; // independence
  logic [2:0] on = 3'h0; // on bits
  logic [2:0] mode = 3'h0; // pwm bits
  logic [17:0] vwr = 18'h00000; // vcode in
  logic [2:0] vwe = 3'h0; // vcode load
  logic [8:0] dly = 9'h000; // delay codes
  logic svc = 1'b0; // host reads
  logic rd; // read pulse
  logic [3:0] thr; // code out
  logic flag, irq_n, up; // status
  logic [2:0] en, ss, good, pwm; // rails
  logic [17:0] vout; // vcodes
  int n_errors = 0; // mismatches
  int num_checks = 0; // checks
  typedef struct {logic [2:0] m; logic [2:0] p;} smrc_row_s;
  smrc_row_s rows [4] = '{'{3'h1, 3'h1}, '{3'h2, 3'h2}, '{3'h4, 3'h4}, '{3'h0, 3'h0}};
  always #5 mclk = ~mclk;
  smrc_top uut (.mclk(mclk), .rst_b(rst_b), .supply_below_cmp(lo), .over_temp_cmp(hot),
    .pushbutton_input(btn), .supply_threshold_code_wr(twr), .supply_threshold_code_we(twe),
    .supply_low_response_select(sel), .supply_alarm_unmask(unm), .supply_low_flag_rd(rd),
    .rail3_button_independence(ind), .rail_on(on), .rail_delay(dly), .rail_mode(mode),
    .vcode_wr(vwr), .vcode_we(vwe), .supply_threshold_code(thr), .supply_low_flag(flag),
    .interrupt_request_n(irq_n), .powered_up(up), .rail_enable(en), .rail_soft_start(ss),
    .rail_good(good), .rail_force_pwm(pwm), .output_voltage_code(vout));
  smrc_host_model host (.mclk(mclk), .service(svc), .interrupt_request_n(irq_n),
    .supply_low_flag_rd(rd));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // selects a watched output
  function automatic logic pick(input int k);
    case (k)
      3: return good[0];
      4: return irq_n;
      5: return up;
      default: return en[k];
    endcase
  endfunction
  // bounded wait for a level
  task automatic wt(input int k, input logic v, input int n);
    for (int i = 0; i < n && pick(k) !== v; i++) tick(1);
    chk(pick(k), v);
    if (pick(k) !== v) wrap_up;
  endtask
  initial begin
    tick(20);
    chk(thr, smrc_pkg::THR_CODE_RESET);
    rst_b = 1'b1;
    wt(5, 1'b1, 10);
    chk(flag, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      twr = 4'(i);
      twe = 1'b1;
      tick(1);
      twe = 1'b0;
      tick(1);
      chk(thr, 18'(i));
    end
    foreach (rows[i]) begin
      mode = rows[i].m;
      tick(3);
      chk(pwm, rows[i].p);
    end
    on[0] = 1'b1;
    wt(0, 1'b1, 10);
    chk(ss[0], 1'b1);
    tick(39000);
    chk(good[0], 1'b0);
    wt(3, 1'b1, 2000);
    chk(vout, {3{smrc_pkg::VCODE_RESET}});
    vwr = 18'h0002A;
    vwe = 3'h1;
    tick(1);
    vwe = 3'h0;
    tick(1);
    chk(vout, 18'h0002A);
    on[0] = 1'b0;
    wt(0, 1'b0, 10);
    tick(20);
    chk(en, 3'h0);
    dly = 9'h008;
    on[1] = 1'b1;
    tick(200);
    chk(en[1], 1'b0);
    on[1] = 1'b0;
    tick(2);
    chk(en[1], 1'b0);
    dly = 9'h000;
    btn = 1'b1;
    wt(2, 1'b1, 10);
    btn = 1'b0;
    on[2] = 1'b1;
    tick(4);
    on[2] = 1'b0;
    wt(2, 1'b0, 10);
    ind = 1'b1;
    btn = 1'b1;
    tick(20);
    chk(en[2], 1'b0);
    btn = 1'b0;
    unm = 1'b0;
    lo = 1'b1;
    tick(20);
    chk(irq_n, 1'b1);
    lo = 1'b0;
    tick(10);
    unm = 1'b1;
    lo = 1'b1;
    wt(4, 1'b0, 10);
    chk(flag, 1'b1);
    lo = 1'b0;
    tick(20);
    chk(irq_n, 1'b0);
    svc = 1'b1;
    wt(4, 1'b1, 10);
    svc = 1'b0;
    on[1] = 1'b1;
    wt(1, 1'b1, 10);
    hot = 1'b1;
    wt(1, 1'b0, 10);
    on[1] = 1'b0;
    tick(4);
    on[1] = 1'b1;
    tick(20);
    chk(en, 3'h0);
    hot = 1'b0;
    on[1] = 1'b0;
    sel = 1'b0;
    tick(10);
    on[0] = 1'b1;
    wt(0, 1'b1, 10);
    lo = 1'b1;
    wt(5, 1'b0, 10);
    tick(2);
    chk({irq_n, en}, 4'h8);
    wrap_up;
  end
endmodule
